// file: core/ord_map.svh
// Address map, field positions, reset values and sizes of the on-chip RAM decode block
`ifndef ORD_MAP_SVH
`define ORD_MAP_SVH

// RAM window, inclusive bounds
`define ORD_RAM_BASE 16'hef80
`define ORD_RAM_LAST 16'hff7f
// RAM size in bytes
`define ORD_RAM_BYTES 4096

// System control register byte address
`define ORD_SYS_CTRL_ADDR 16'hfff4

// System control register fields
`define ORD_SC_STANDBY_SEL 7
`define ORD_SC_TIMER_SEL_HI 6
`define ORD_SC_TIMER_SEL_LO 4
`define ORD_SC_EXT_RST_FLAG 3
`define ORD_SC_NMI_EDGE 2
`define ORD_SC_HOST_IF_EN 1
`define ORD_SC_RAM_ENABLE 0
// Reset value and writable-bit mask
`define ORD_SC_RESET 8'h09
`define ORD_SC_WR_MASK 8'hf7

// Answer to a read of a deselected window in single-chip mode
`define ORD_FILL_BYTE 8'hff
// Answer to a read of an unmapped address
`define ORD_UNMAPPED_DATA 16'h0000

`endif

// file: core/ord_pkg.sv
// Types shared by the on-chip RAM decode block
package ord_pkg;

    // Operating mode as read from the mode pins
    typedef enum logic [1:0] {
        ORD_MODE_NONE = 2'h0,
        ORD_MODE_EXP1 = 2'h1,
        ORD_MODE_EXP2 = 2'h2,
        ORD_MODE_SINGLE = 2'h3
    } ord_mode_t;

    // Request from the processor core
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic byte_acc;
    } ord_req_t;

    // Access forwarded to the external data bus
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic byte_acc;
    } ord_ext_t;

    // Source of the read answer in the cycle after a read
    typedef enum logic [2:0] {
        ORD_SRC_ZERO,
        ORD_SRC_RAM,
        ORD_SRC_REG,
        ORD_SRC_FILL,
        ORD_SRC_EXT
    } ord_src_t;

endpackage

// file: core/ord_ram_array.sv
// Word-wide static RAM array with byte-lane write enables and registered read
`timescale 1ns/100ps
`default_nettype none

module ord_ram_array #(
    parameter int WORDS = 2048,
    parameter int WIDTH = 16,
    parameter int AW = 11
) (
    // Clock and enable
    input wire logic i_clk,
    input wire logic i_ce,
    // Access port
    input wire logic [AW-1:0] i_index,
    input wire logic [WIDTH/8-1:0] i_lane_we,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_rd,
    output logic [WIDTH-1:0] o_rdata
);

    // Refuse shapes the lane logic and index cannot serve
    initial begin
        if (WIDTH % 8 != 0 || WORDS > (1 << AW) || WORDS < 1) begin
            $error("ord_ram_array: unsupported WIDTH/WORDS/AW");
        end
    end

    // Storage in flip-flops; contents are not cleared by reset
    logic [WIDTH-1:0] mem_q [WORDS];
    logic [WIDTH-1:0] rdata_q;

    // Lane-wise write, only the enabled lanes change
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            for (int l = 0; l < WIDTH / 8; l++) begin
                if (i_lane_we[l]) begin
                    mem_q[i_index][l*8 +: 8] <= i_wdata[l*8 +: 8];
                end
            end
        end
    end

    // Registered read, answer stands the cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_ce && i_rd) begin
            rdata_q <= mem_q[i_index];
        end
    end

    assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// file: core/ord_top.sv
// On-chip RAM with address decode and the system control register
// Limitations
// Byte lanes are big-endian: an even address selects bits 15:8.
// Byte reads come back right-justified, with the upper lane zero.
// Mode pin code 0 is served like single-chip mode.
// Reset leaves the RAM contents as they were; nothing clears the array.
// Forwarded reads need the external data settled within the request cycle.
// The control register sits at a fixed address on the same core bus.
`timescale 1ns/100ps
`default_nettype none
`include "ord_map.svh"

module ord_top #(
    parameter int RAM_BYTES = `ORD_RAM_BYTES,
    parameter int DATA_W = 16
) (
    // Clock, reset and clock enable
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // Mode pins and standby status
    input wire logic [1:0] I_MODE_PIN,
    input wire logic I_STANDBY,
    // Processor core bus
    input wire ord_pkg::ord_req_t I_REQ,
    output logic [15:0] O_RDATA,
    // External data bus
    output ord_pkg::ord_ext_t O_EXT,
    input wire logic [15:0] I_EXT_RDATA,
    // Control outputs to the rest of the chip
    output logic [7:0] O_SYS_CTRL,
    output logic O_RAM_ENABLED
);

    localparam int RAM_WORDS = RAM_BYTES / 2;
    localparam int RAM_AW = $clog2(RAM_WORDS);

    // Refuse sizes that do not fit the fixed window or the 16-bit path
    initial begin
        if (DATA_W != 16) begin
            $error("ord_top: DATA_W must be 16");
        end
        if (RAM_BYTES != (`ORD_RAM_LAST - `ORD_RAM_BASE + 1)) begin
            $error("ord_top: RAM_BYTES must match the address window");
        end
        if (RAM_BYTES % 2 != 0) begin
            $error("ord_top: RAM_BYTES must be a whole number of words");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions
    // Shared by the decode, the RAM index and the lane enables

    // True when the address lies inside the RAM window
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= `ORD_RAM_BASE) && (a <= `ORD_RAM_LAST);
    endfunction

    // The window base is subtracted first so bit 0 of the offset is the lane
    // Word index inside the RAM for a window address
    function automatic logic [RAM_AW-1:0] word_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - `ORD_RAM_BASE;
        word_index = off[RAM_AW:1];
    endfunction

    // A word access ignores address bit 0 and writes both lanes
    // Byte lane enables; even address is the upper lane
    function automatic logic [1:0] lane_sel(input logic byte_acc, input logic a0);
        if (!byte_acc) begin
            lane_sel = 2'h3;
        end else if (a0) begin
            lane_sel = 2'h1;
        end else begin
            lane_sel = 2'h2;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Mode pin synchroniser

    logic [1:0] mode_meta_q;
    logic [1:0] mode_sync_q;

    // Reset loads single-chip so a disabled window never leaks outward
    // before the pins have been seen twice
    // Two flip-flops before the mode pins reach any decode
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            mode_meta_q <= 2'h3;
            mode_sync_q <= 2'h3;
        end else if (I_CE) begin
            mode_meta_q <= I_MODE_PIN;
            mode_sync_q <= mode_meta_q;
        end
    end

    // Unused pin code is served like single-chip mode
    ord_pkg::ord_mode_t mode;
    wire logic expanded;
    assign mode = ord_pkg::ord_mode_t'(mode_sync_q);
    assign expanded = (mode == ord_pkg::ORD_MODE_EXP1) || (mode == ord_pkg::ORD_MODE_EXP2);

    ////////////////////////////////////////////////////////////////////////////////
    // System control register

    logic [7:0] sys_ctrl_q;
    logic [7:0] sys_ctrl_d;
    wire logic ram_enable;

    // Address decode of the request
    wire logic hit_window;
    wire logic hit_reg;
    wire logic reg_wr;
    assign hit_window = in_window(I_REQ.addr);
    assign hit_reg = (I_REQ.addr == `ORD_SYS_CTRL_ADDR);
    assign reg_wr = I_CE && I_REQ.wr && hit_reg;

    // Byte written to the register comes on the low lane
    wire logic [7:0] reg_wbyte;
    assign reg_wbyte = I_REQ.wdata[7:0];

    // Writable bits take the new value, bit 3 keeps its read-only 1
    assign sys_ctrl_d = (sys_ctrl_q & ~`ORD_SC_WR_MASK) | (reg_wbyte & `ORD_SC_WR_MASK);

    // The write happens only with the clock enable high, so a frozen
    // block never takes a register write
    // Reset loads enable=1 and flag=1; standby has no path into this register
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            sys_ctrl_q <= `ORD_SC_RESET;
        end else if (reg_wr) begin
            sys_ctrl_q <= sys_ctrl_d;
        end
    end

    // Both outputs follow the register directly, with no extra delay
    // Enable bit steers the window decode
    assign ram_enable = sys_ctrl_q[`ORD_SC_RAM_ENABLE];
    assign O_SYS_CTRL = sys_ctrl_q;
    assign O_RAM_ENABLED = ram_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Window routing

    // Window access served by the RAM whenever enabled, any mode
    wire logic to_ram;
    // Window access forwarded outward in expanded modes when disabled
    wire logic to_ext;
    // Window access blocked in single-chip mode when disabled
    wire logic to_fill;
    // Exactly one route is taken for a window address, none outside it
    assign to_ram = hit_window && ram_enable;
    assign to_ext = hit_window && !ram_enable && expanded;
    assign to_fill = hit_window && !ram_enable && !expanded;

    // Standby has no effect on routing; the input is only observed
    wire logic standby_seen;
    assign standby_seen = I_STANDBY;

    ////////////////////////////////////////////////////////////////////////////////
    // RAM array

    wire logic [RAM_AW-1:0] ram_index;
    wire logic [1:0] ram_lanes;
    wire logic [1:0] ram_we;
    wire logic ram_rd;
    wire logic [15:0] ram_wdata;
    wire logic [15:0] ram_rdata;

    // The RAM sees only window addresses it owns; other requests leave
    // the lane enables and read strobe low so the array stays idle
    // Byte write data is replicated onto both lanes, the lane enable picks one
    assign ram_index = word_index(I_REQ.addr);
    assign ram_lanes = lane_sel(I_REQ.byte_acc, I_REQ.addr[0]);
    assign ram_wdata = I_REQ.byte_acc ? {I_REQ.wdata[7:0], I_REQ.wdata[7:0]} : I_REQ.wdata;
    // Writes reach the array only when routed to the RAM
    assign ram_we = (I_REQ.wr && to_ram && !standby_seen | I_REQ.wr && to_ram) ? ram_lanes : 2'h0;
    assign ram_rd = I_REQ.rd && to_ram;

    // The 4 kbyte array on the 16-bit path
    ord_ram_array #(
        .WORDS(RAM_WORDS),
        .WIDTH(16),
        .AW(RAM_AW)
    ) u_array (
        .i_clk(I_CORE_CLK),
        .i_ce(I_CE),
        .i_index(ram_index),
        .i_lane_we(ram_we),
        .i_wdata(ram_wdata),
        .i_rd(ram_rd),
        .o_rdata(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // External bus forwarding

    // Combinational path from the core request to the pins; the far side
    // sees the access in the same cycle and must answer within it
    // Forwarded access mirrors the core request in the same cycle
    always_comb begin
        O_EXT = '0;
        if (I_CE && to_ext) begin
            O_EXT.addr = I_REQ.addr;
            O_EXT.wdata = I_REQ.wdata;
            O_EXT.wr = I_REQ.wr;
            O_EXT.rd = I_REQ.rd;
            O_EXT.byte_acc = I_REQ.byte_acc;
        end
    end

    // Held until the next forwarded read, so a frozen clock keeps it
    // External read answer is captured at the end of the request cycle
    logic [15:0] ext_rdata_q;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ext_rdata_q <= 16'h0000;
        end else if (I_CE && I_REQ.rd && to_ext) begin
            ext_rdata_q <= I_EXT_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answer

    ord_pkg::ord_src_t src_d;
    ord_pkg::ord_src_t src_q;
    logic byte_q;
    logic a0_q;

    // Window and register addresses never overlap, so order is free
    // Pick the source of the next-cycle answer
    always_comb begin
        src_d = ord_pkg::ORD_SRC_ZERO;
        if (to_ram) begin
            src_d = ord_pkg::ORD_SRC_RAM;
        end else if (to_ext) begin
            src_d = ord_pkg::ORD_SRC_EXT;
        end else if (to_fill) begin
            src_d = ord_pkg::ORD_SRC_FILL;
        end else if (hit_reg) begin
            src_d = ord_pkg::ORD_SRC_REG;
        end
    end

    // Remember what was read so the answer stands one cycle later
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            src_q <= ord_pkg::ORD_SRC_ZERO;
            byte_q <= 1'b0;
            a0_q <= 1'b0;
        end else if (I_CE) begin
            src_q <= I_REQ.rd ? src_d : ord_pkg::ORD_SRC_ZERO;
            byte_q <= I_REQ.byte_acc;
            a0_q <= I_REQ.addr[0];
        end
    end

    // Stored byte select picks the lane that was addressed one cycle ago
    // Byte reads answer on the low lane, upper lane zero
    wire logic [15:0] ram_answer;
    wire logic [15:0] ext_answer;
    wire logic [15:0] fill_answer;
    assign ram_answer = !byte_q ? ram_rdata :
        {8'h00, (a0_q ? ram_rdata[7:0] : ram_rdata[15:8])};
    assign ext_answer = !byte_q ? ext_rdata_q : {8'h00, ext_rdata_q[7:0]};
    // Blocked window reads give all ones in each byte read
    assign fill_answer = byte_q ? {8'h00, `ORD_FILL_BYTE} : {`ORD_FILL_BYTE, `ORD_FILL_BYTE};

    // Unmapped reads and cycles without a read both answer zero
    // Answer mux, stands in the cycle after the read and longer while I_CE stays low
    always_comb begin
        unique case (src_q)
            ord_pkg::ORD_SRC_ZERO: O_RDATA = `ORD_UNMAPPED_DATA;
            ord_pkg::ORD_SRC_RAM: O_RDATA = ram_answer;
            ord_pkg::ORD_SRC_REG: O_RDATA = {8'h00, sys_ctrl_q};
            ord_pkg::ORD_SRC_FILL: O_RDATA = fill_answer;
            ord_pkg::ORD_SRC_EXT: O_RDATA = ext_answer;
            default: O_RDATA = `ORD_UNMAPPED_DATA;
        endcase
    end

endmodule

`default_nettype wire

// file: sim/ord_ext_model.sv
// Behavioural device on the external data bus
`timescale 1ns/100ps
`default_nettype none

module ord_ext_model (
    // Clock
    input wire logic i_clk,
    // Forwarded access and answer
    input wire ord_pkg::ord_ext_t i_ext,
    output logic [15:0] o_rdata
);
    logic [15:0] noise_q = 16'h0000;

    // Pattern that changes every cycle while nothing is read
    always @(posedge i_clk) begin
        noise_q <= noise_q + 16'h9e37;
    end

    // Prompt answer derived from the address
    assign o_rdata = i_ext.rd ? {i_ext.addr[7:0], ~i_ext.addr[7:0]} : noise_q;
endmodule

`default_nettype wire

// file: sim/ord_top_monitor.sv
// Concurrent checks on the ports of the on-chip RAM decode block
`timescale 1ns/100ps
`default_nettype none
`include "ord_map.svh"

module ord_top_monitor (
    // Clock and control
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic [1:0] I_MODE_PIN,
    input wire logic I_STANDBY,
    // Buses and register view
    input wire ord_pkg::ord_req_t I_REQ,
    input wire logic [15:0] O_RDATA,
    input wire ord_pkg::ord_ext_t O_EXT,
    input wire logic [15:0] I_EXT_RDATA,
    input wire logic [7:0] O_SYS_CTRL,
    input wire logic O_RAM_ENABLED
);
    logic [1:0] m1_q;
    logic [1:0] m2_q;

    // Mode pins seen through two stages, like the block itself
    always_ff @(posedge I_CORE_CLK) begin
        m1_q <= I_MODE_PIN;
        m2_q <= m1_q;
    end

    // Access decode
    wire logic steady = I_MODE_PIN == m1_q && m1_q == m2_q;
    wire logic exp_md = I_MODE_PIN == 2'h1 || I_MODE_PIN == 2'h2;
    wire logic acc = I_CE && (I_REQ.wr || I_REQ.rd);
    wire logic in_win = acc && I_REQ.addr >= `ORD_RAM_BASE && I_REQ.addr <= `ORD_RAM_LAST;
    wire logic reg_wr = I_CE && I_REQ.wr && I_REQ.addr == `ORD_SYS_CTRL_ADDR;
    wire logic off_win = in_win && !O_RAM_ENABLED && steady;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    ////////////////////////////////////////////////////////////////////////
    chk_reset_value: assert property (disable iff (1'b0)
        I_RST |=> O_SYS_CTRL == `ORD_SC_RESET && O_RAM_ENABLED) else $error("bad reset value");
    chk_enable_bit: assert property (O_RAM_ENABLED == O_SYS_CTRL[0])
        else $error("enable output differs from bit 0");
    chk_reg_hold: assert property (!reg_wr |=> $stable(O_SYS_CTRL))
        else $error("control register changed without a write");
    chk_reg_write: assert property (reg_wr |=>
        O_SYS_CTRL == (($past(I_REQ.wdata[7:0]) & `ORD_SC_WR_MASK) | 8'h08))
        else $error("control register write wrong");
    chk_ram_keeps: assert property (in_win && O_RAM_ENABLED |-> !O_EXT.wr && !O_EXT.rd)
        else $error("enabled window leaked to external bus");
    chk_fwd_bus: assert property (off_win && exp_md |-> O_EXT == ord_pkg::ord_ext_t'(I_REQ))
        else $error("window access not forwarded");
    chk_fwd_data: assert property (off_win && exp_md && I_REQ.rd |=>
        O_RDATA == ($past(I_REQ.byte_acc) ? {8'h00, $past(I_EXT_RDATA[7:0])}
        : $past(I_EXT_RDATA))) else $error("forwarded read data wrong");
    chk_fill_read: assert property (off_win && !exp_md && I_REQ.rd |=>
        O_RDATA == ($past(I_REQ.byte_acc) ? 16'h00ff : 16'hffff)) else $error("fill read wrong");
    chk_single_quiet: assert property (off_win && !exp_md |-> O_EXT == '0)
        else $error("single-chip access reached external bus");

    // Main scenarios
    cover property (off_win && exp_md && I_REQ.rd);
    cover property (off_win && !exp_md && I_REQ.wr);
    cover property (reg_wr);
    cover property (in_win && O_RAM_ENABLED && I_REQ.byte_acc && I_REQ.wr);
endmodule

bind ord_top ord_top_monitor i_ord_top_monitor (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
    .I_CE(I_CE), .I_MODE_PIN(I_MODE_PIN), .I_STANDBY(I_STANDBY), .I_REQ(I_REQ),
    .O_RDATA(O_RDATA), .O_EXT(O_EXT), .I_EXT_RDATA(I_EXT_RDATA), .O_SYS_CTRL(O_SYS_CTRL),
    .O_RAM_ENABLED(O_RAM_ENABLED));

`default_nettype wire

// file: sim/ord_top_tb_top.sv
// Self-checking bench for the on-chip RAM decode block
`timescale 1ns/100ps
`default_nettype none

module ord_top_tb_top;
    logic clk = 1'b0;
    logic rst, ce, stby, ram_en;
    logic [1:0] mode;
    ord_pkg::ord_req_t req;
    ord_pkg::ord_ext_t ext;
    logic [15:0] rdata, ext_rdata;
    logic [7:0] sys_ctrl;
    logic [7:0] mem [0:4095];
    logic [15:0] exp_q [$];
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    bit rd_seen = 1'b0;

    always #4 clk = ~clk;

    ord_top i_ord_top (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_MODE_PIN(mode),
        .I_STANDBY(stby), .I_REQ(req), .O_RDATA(rdata), .O_EXT(ext),
        .I_EXT_RDATA(ext_rdata), .O_SYS_CTRL(sys_ctrl), .O_RAM_ENABLED(ram_en));
    ord_ext_model i_ord_ext_model (.i_clk(clk), .i_ext(ext), .o_rdata(ext_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One request per call; reads leave their expected answer in the queue
    task automatic op(input bit w, input bit b, input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] e);
        @(posedge clk);
        req <= '{a, d, w, !w, b};
        if (!w) exp_q.push_back(e);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            req <= '0;
        end
    endtask

    // RAM access with the reference copy updated; even byte is the upper lane
    task automatic rop(input bit w, input bit b, input logic [15:0] a, input logic [15:0] d);
        int i;
        logic [15:0] e;
        i = int'(a - 16'hef80);
        if (w && b) mem[i] = d[7:0];
        if (w && !b) {mem[i & ~1], mem[i | 1]} = d;
        e = b ? {8'h00, mem[i]} : {mem[i & ~1], mem[i | 1]};
        op(w, b, a, d, e);
    endtask

    task automatic setmode(input logic [1:0] m);
        idle(1);
        mode <= m;
        idle(3);
    endtask

    // Watcher: the answer stands in the cycle after the read
    always @(posedge clk) begin
        if (rd_seen) chk16(rdata, exp_q.pop_front());
        rd_seen <= ce && req.rd && !rst;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        rst = 1'b1;
        ce = 1'b1;
        stby = 1'b0;
        mode = 2'h3;
        void'($urandom(26895));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        idle(3);
        op(0, 0, 16'hfff4, 16'h0000, 16'h0009);
        // Every location written before use, then mixed random traffic
        for (int k = 0; k < 2048; k++) rop(1, 0, 16'hef80 + 16'(2 * k), 16'($urandom));
        rop(0, 1, 16'hef80, 16'h0000);
        rop(0, 1, 16'hff7f, 16'h0000);
        for (int k = 0; k < 300; k++) begin
            rop(1'($urandom), 1'($urandom), 16'hef80 + 16'($urandom % 4096), 16'($urandom));
        end
        rop(0, 0, 16'hff7e, 16'h0000);
        op(0, 0, 16'hff80, 16'h0000, 16'h0000);
        op(1, 0, 16'hfff4, 16'h00ff, 16'h0000);
        op(0, 0, 16'hfff4, 16'h0000, 16'h00ff);
        op(1, 0, 16'hfff4, 16'h0000, 16'h0000);
        op(0, 0, 16'hfff4, 16'h0000, 16'h0008);
        // Disabled in single-chip mode
        op(1, 0, 16'hef80, ~{mem[0], mem[1]}, 16'h0000);
        op(1, 1, 16'hff7f, {8'h00, ~mem[4095]}, 16'h0000);
        op(0, 1, 16'hef81, 16'h0000, 16'h00ff);
        op(0, 0, 16'hf000, 16'h0000, 16'hffff);
        idle(2);
        stby <= 1'b1;
        idle(4);
        op(0, 0, 16'hfff4, 16'h0000, 16'h0008);
        stby <= 1'b0;
        op(1, 0, 16'hfff4, 16'h0001, 16'h0000);
        rop(0, 0, 16'hef80, 16'h0000);
        rop(0, 1, 16'hff7f, 16'h0000);
        // Clock enable low drops the request
        idle(1);
        ce <= 1'b0;
        op(1, 0, 16'hfff4, 16'h0000, 16'h0000);
        idle(1);
        ce <= 1'b1;
        op(0, 0, 16'hfff4, 16'h0000, 16'h0009);
        // Expanded modes forward the window while disabled
        for (int m = 1; m < 3; m++) begin
            setmode(2'(m));
            op(1, 0, 16'hfff4, 16'h0000, 16'h0000);
            for (int k = 0; k < 4; k++) begin
                logic [15:0] a;
                bit b;
                a = 16'hef80 + 16'($urandom % 4096);
                b = 1'($urandom);
                op(1, 1'($urandom), a, 16'($urandom), 16'h0000);
                op(0, b, a, 16'h0000, b ? {8'h00, ~a[7:0]} : {a[7:0], ~a[7:0]});
            end
            op(1, 0, 16'hfff4, 16'h0001, 16'h0000);
            rop(0, 0, 16'hff7e, 16'h0000);
            op(1, 0, 16'hfff4, 16'h0000, 16'h0000);
        end
        // Pin code 0 behaves as single-chip while disabled
        setmode(2'h0);
        op(0, 1, 16'hf000, 16'h0000, 16'h00ff);
        op(1, 0, 16'hef80, 16'h1234, 16'h0000);
        // Second reset re-enables the RAM and keeps its contents
        idle(1);
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        idle(3);
        op(0, 0, 16'hfff4, 16'h0000, 16'h0009);
        rop(0, 0, 16'hef80, 16'h0000);
        idle(4);
        tally_and_finish();
    end
endmodule

`default_nettype wire
